// ==== dv/flash_model.sv ====
// Behavioural flash macro that sits on the far side of the sequencer.
// Assumes the sequencer issues one-cycle start pulses on pclk.
`timescale 1ns/1ps
module flash_model #(
   parameter int DONE_CYC = 8
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [14:0] flash_raddr,
   input  wire logic        prog_erase,
   input  wire logic        prog_write,
   output      logic [15:0] flash_rdata,
   output      logic        prog_done
);
   int cnt_q;

   ////////////////////////////////////////////////////////////////////////////
   // Each word holds its own low address byte and its inverse, so both bytes differ.
   assign flash_rdata = {~flash_raddr[7:0], flash_raddr[7:0]};

   // A start pulse arms a fixed busy time; prog_done pulses once when it runs out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q     <= 0;
         prog_done <= 1'b0;
      end else begin
         prog_done <= (cnt_q == 1);
         if (prog_erase || prog_write) begin
            cnt_q <= DONE_CYC;
         end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the boot partition sequencer, 16 KB variant.
// Assumes the flash model answers every program start with prog_done.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_top;
   import zmap_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        fuse_hi, fuse_lo, prog_done, prog_erase, prog_write, cpu_stall;
   logic [7:0]  paddr, prog_page;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] flash_rdata, buf_rd_word, boot_reset_addr;
   logic [14:0] flash_raddr;
   logic [6:0]  buf_rd_idx;
   int          bad_count, tests_run, wr_n, er_n;

   ////////////////////////////////////////////////////////////////////////////
   boot_partition_zmap #(.VARIANT(VAR_16K)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boot_size_fuse_hi(fuse_hi),
      .boot_size_fuse_lo(fuse_lo), .flash_rdata(flash_rdata),
      .flash_raddr(flash_raddr), .prog_done(prog_done), .prog_page(prog_page),
      .prog_erase(prog_erase), .prog_write(prog_write), .buf_rd_idx(buf_rd_idx),
      .buf_rd_word(buf_rd_word), .cpu_stall(cpu_stall),
      .boot_reset_addr(boot_reset_addr));

   flash_model u_flash (
      .pclk(pclk), .presetn(presetn), .flash_raddr(flash_raddr),
      .prog_erase(prog_erase), .prog_write(prog_write),
      .flash_rdata(flash_rdata), .prog_done(prog_done));

   // The clock runs free at 40 MHz.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Start pulses are counted so that a lapsed command can be seen to do nothing.
   always @(posedge pclk) begin
      if (prog_write === 1'b1) wr_n++;
      if (prog_erase === 1'b1) er_n++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("mismatches %0d, comparisons %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // One APB transfer; psel stays high so a second transfer can follow at once.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Right after the edge the outputs still show what the edge sampled.
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         bad_count++;
         finish_test();
      end else begin
         rd      = prdata;
         er      = pslverr;
         penable <= 1'b0;
      end
   endtask

   task automatic rel();
      psel <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      rel();
   endtask

   task automatic rdr(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      rel();
   endtask

   // Command bits and the store instruction go out back to back, as the window demands.
   task automatic cmd(input logic [31:0] c);
      apb(1'b1, CTRL_OFS, c);
      apb(1'b1, STORE_OFS, 32'h0);
      rel();
   endtask

   // Polls store enable until it reads clear, with a bound. The bench has no
   // EEPROM, so no EEPROM write is ever pending when a command starts.
   task automatic wait_idle();
      int n;
      for (n = 0; n < 40; n++) begin
         rdr(CTRL_OFS);
         if (rd[SE_BIT] === 1'b0) break;
      end
      `CHK(rd[SE_BIT], 1'b0)
   endtask

   task automatic do_reset(input logic [1:0] f);
      presetn <= 1'b0;
      fuse_hi <= f[1];
      fuse_lo <= f[0];
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_boot();
      logic [15:0] exp [4];
      exp = '{16'h1C00, 16'h1E00, 16'h1F00, 16'h1F80};
      for (int f = 0; f < 4; f++) begin
         do_reset(f[1:0]);
         `CHK(boot_reset_addr, exp[f])
         rdr(INFO_OFS);
         `CHK(rd[15:0], exp[f])
      end
   endtask

   task automatic t_region();
      wr(ZPTR_OFS, 32'h37FE);
      rdr(INFO_OFS);
      `CHK(rd[PROT_BIT], 1'b0)
      wr(ZPTR_OFS, 32'h3800);
      rdr(INFO_OFS);
      `CHK(rd[PROT_BIT], 1'b1)
      `CHK(flash_raddr, 15'h1C00)
      rdr(8'h40);
      `CHK(er, 1'b1)
   endtask

   task automatic t_byte();
      wr(ZPTR_OFS, 32'h0123);
      rdr(DATA_OFS);
      `CHK(rd[7:0], 8'h6E)
      wr(ZPTR_OFS, 32'h0122);
      rdr(DATA_OFS);
      `CHK(rd[7:0], 8'h91)
   endtask

   task automatic t_load();
      wr(DATA_OFS, 32'hBEEF);
      wr(ZPTR_OFS, 32'h0006);
      wait_idle();
      cmd(32'h01);
      wait_idle();
      buf_rd_idx <= 7'h03;
      repeat (2) @(posedge pclk);
      #1;
      `CHK(buf_rd_word, 16'hBEEF)
      @(posedge pclk);
   endtask

   // Page write in the readable region, then re-enable it.
   task automatic t_open_write();
      int w0;
      wr(ZPTR_OFS, 32'h0280);
      wait_idle();
      w0 = wr_n;
      cmd(32'h05);
      rdr(CTRL_OFS);
      `CHK(rd[BUSY_BIT], 1'b1)
      `CHK(cpu_stall, 1'b0)
      `CHK(prog_page, 8'h05)
      `CHK(wr_n, w0 + 1)
      rdr(DATA_OFS);
      `CHK(er, 1'b1)
      wait_idle();
      rdr(CTRL_OFS);
      `CHK(rd[BUSY_BIT], 1'b1)
      cmd(32'h11);
      rdr(CTRL_OFS);
      `CHK(rd[BUSY_BIT], 1'b0)
      rdr(DATA_OFS);
      `CHK(er, 1'b0)
   endtask

   task automatic t_lapse();
      int w0;
      wait_idle();
      w0 = wr_n;
      wr(CTRL_OFS, 32'h05);
      repeat (6) @(posedge pclk);
      wr(STORE_OFS, 32'h0);
      rdr(CTRL_OFS);
      `CHK(rd[SE_BIT], 1'b0)
      `CHK(wr_n, w0)
   endtask

   // Erase in the protected region stalls the core and leaves the busy flag alone.
   task automatic t_prot_erase();
      int e0;
      int n;
      wr(ZPTR_OFS, 32'h3800);
      wait_idle();
      e0 = er_n;
      cmd(32'h03);
      #1;
      `CHK(cpu_stall, 1'b1)
      `CHK(prog_page, 8'h70)
      `CHK(er_n, e0 + 1)
      for (n = 0; n < 40; n++) begin
         @(posedge pclk);
         #1;
         if (cpu_stall === 1'b0) break;
      end
      `CHK(cpu_stall, 1'b0)
      // Back onto the edge, so the next request starts right after it.
      @(posedge pclk);
      rdr(CTRL_OFS);
      `CHK(rd[BUSY_BIT], 1'b0)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard: a stuck run still ends in the closing report.
   initial begin
      #500000;
      bad_count++;
      finish_test();
   end

   initial begin
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0;
      buf_rd_idx = 7'h00;
      bad_count  = 0;
      tests_run  = 0;
      wr_n       = 0;
      er_n       = 0;
      // Reset and the fuse pins are first driven inside the first reset.
      t_boot();
      t_region();
      t_byte();
      t_load();
      t_open_write();
      t_lapse();
      t_prot_erase();
      finish_test();
   end
endmodule

// ==== rtl/boot_partition_zmap.sv ====
// Self-programming sequencer: command window, page buffer, region busy and stall.
// Assumes an APB master on pclk and a flash macro that reports completion.
`timescale 1ns/1ps
module boot_partition_zmap #(
   parameter zmap_pkg::variant_t VARIANT = zmap_pkg::VAR_16K
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        boot_size_fuse_hi,
   input  wire logic        boot_size_fuse_lo,
   input  wire logic [15:0] flash_rdata,
   output      logic [14:0] flash_raddr,
   input  wire logic        prog_done,
   output      logic [7:0]  prog_page,
   output      logic        prog_erase,
   output      logic        prog_write,
   input  wire logic [6:0]  buf_rd_idx,
   output      logic [15:0] buf_rd_word,
   output      logic        cpu_stall,
   output      logic [15:0] boot_reset_addr
);
   import zmap_pkg::*;

   localparam int          PWT      = PAGE_TOP[VARIANT];
   localparam int          PCT      = PC_TOP[VARIANT];
   localparam logic [16:0] FLASH_W  = 17'(1 << (PCT + 1));
   localparam logic [15:0] WMASK    = 16'((1 << (PWT + 1)) - 1);
   localparam logic [15:0] PMASK    = 16'((1 << (PCT - PWT)) - 1);
   localparam logic [15:0] BOOT_RST = 16'(FLASH_W - 17'(BOOT_MIN[VARIANT]));

   zmap_if dz ();

   seq_state_t  st_q;
   logic [2:0]  win_q;
   logic        store_enable_q, cmd_erase_q, cmd_write_q, cmd_reen_q;
   logic        region_busy_q;
   logic [15:0] zptr_q, data_q;
   logic [1:0]  fuse_meta_q, fuse_q;
   logic [31:0] prdata_q, rd_d;
   logic        pready_q, pslverr_q, err_d;
   logic [14:0] flash_raddr_q;
   logic [7:0]  prog_page_q;
   logic        prog_erase_q, prog_write_q, cpu_stall_q;
   logic [15:0] buf_rd_word_q, boot_reset_addr_q;
   logic [15:0] buf_mem [128];
   logic        acc, wr_go, wr_ctrl, spm_go, blocked;
   logic        prog_start, reen_go, load_go;

   zmap_decode #(.VARIANT(VARIANT)) u_dec (.z(dz));

   assign dz.zptr = zptr_q;
   assign dz.fuse = fuse_q;

   //////////////////////////////////////////////////////////////////////////
   // APB decode. One wait state lets read data come from a flop.
   assign acc     = psel & penable & ~pready_q;
   assign wr_go   = psel & penable & pready_q & pwrite;
   assign wr_ctrl = wr_go && (paddr == CTRL_OFS);
   assign spm_go  = wr_go && (paddr == STORE_OFS);
   assign blocked = region_busy_q & ~dz.in_prot;

   // Command outcomes when the store instruction lands inside the window.
   assign prog_start = (st_q == ST_ARMED) && spm_go && (cmd_erase_q || cmd_write_q);
   assign reen_go    = (st_q == ST_ARMED) && spm_go && !cmd_erase_q && !cmd_write_q
                       && cmd_reen_q;
   assign load_go    = (st_q == ST_ARMED) && spm_go && !cmd_erase_q && !cmd_write_q
                       && !cmd_reen_q;

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign flash_raddr     = flash_raddr_q;
   assign prog_page       = prog_page_q;
   assign prog_erase      = prog_erase_q;
   assign prog_write      = prog_write_q;
   assign buf_rd_word     = buf_rd_word_q;
   assign cpu_stall       = cpu_stall_q;
   assign boot_reset_addr = boot_reset_addr_q;

   //////////////////////////////////////////////////////////////////////////
   // Fuse pins are static straps but still come from outside the clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_meta_q <= FUSE_RST;
         fuse_q      <= FUSE_RST;
      end else begin
         fuse_meta_q <= {boot_size_fuse_hi, boot_size_fuse_lo};
         fuse_q      <= fuse_meta_q;
      end
   end

   // Boot reset address follows the synchronised fuse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_reset_addr_q <= BOOT_RST;
      end else begin
         boot_reset_addr_q <= dz.boot_start;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pointer and load-data registers; the flash read address tracks the pointer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zptr_q        <= 16'h0000;
         data_q        <= 16'h0000;
         flash_raddr_q <= 15'h0000;
      end else begin
         if (wr_go && (paddr == ZPTR_OFS)) begin
            zptr_q <= pwdata[15:0];
         end
         if (wr_go && (paddr == DATA_OFS)) begin
            data_q <= pwdata[15:0];
         end
         flash_raddr_q <= zptr_q[15:1];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Command sequencer. A new command is only taken while idle, which is
   // why software must see store enable clear before writing again.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q           <= ST_IDLE;
         win_q          <= 3'h0;
         store_enable_q <= 1'b0;
         cmd_erase_q    <= 1'b0;
         cmd_write_q    <= 1'b0;
         cmd_reen_q     <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (wr_ctrl && pwdata[SE_BIT]) begin
                  st_q           <= ST_ARMED;
                  win_q          <= WIN_CYC;
                  store_enable_q <= 1'b1;
                  cmd_erase_q    <= pwdata[ERASE_BIT];
                  cmd_write_q    <= pwdata[WRITE_BIT];
                  cmd_reen_q     <= pwdata[REEN_BIT];
               end
            end
            ST_ARMED: begin
               if (prog_start) begin
                  st_q <= ST_PROG;
               end else if (spm_go || win_q == WIN_LAST) begin
                  st_q           <= ST_IDLE;
                  store_enable_q <= 1'b0;
                  cmd_erase_q    <= 1'b0;
                  cmd_write_q    <= 1'b0;
                  cmd_reen_q     <= 1'b0;
               end else begin
                  win_q <= win_q - 3'h1;
               end
            end
            ST_PROG: begin
               if (prog_done) begin
                  st_q           <= ST_IDLE;
                  store_enable_q <= 1'b0;
                  cmd_erase_q    <= 1'b0;
                  cmd_write_q    <= 1'b0;
                  cmd_reen_q     <= 1'b0;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Region busy: set when the readable region is programmed, cleared by a
   // re-enable or by a page load. The set case cannot meet a clear case.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         region_busy_q <= 1'b0;
      end else if (prog_start && !dz.in_prot) begin
         region_busy_q <= 1'b1;
      end else if (reen_go || load_go) begin
         region_busy_q <= 1'b0;
      end
   end

   // Flash macro strobes and the core stall for the protected region.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_page_q  <= 8'h00;
         prog_erase_q <= 1'b0;
         prog_write_q <= 1'b0;
         cpu_stall_q  <= 1'b0;
      end else begin
         prog_erase_q <= prog_start && cmd_erase_q;
         prog_write_q <= prog_start && cmd_write_q && !cmd_erase_q;
         if (prog_start) begin
            prog_page_q <= dz.page_sel;
            cpu_stall_q <= dz.in_prot;
         end else if (prog_done) begin
            cpu_stall_q <= 1'b0;
         end
      end
   end

   // Temporary page buffer; not reset since it only holds data.
   always_ff @(posedge pclk) begin
      if (load_go) begin
         buf_mem[dz.word_sel] <= data_q;
      end
      buf_rd_word_q <= buf_mem[buf_rd_idx];
   end

   //////////////////////////////////////////////////////////////////////////
   // Read mux. Reads of the busy region answer with an error, not stale data.
   always_comb begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      case (paddr)
         CTRL_OFS: begin
            rd_d[SE_BIT]    = store_enable_q;
            rd_d[ERASE_BIT] = cmd_erase_q;
            rd_d[WRITE_BIT] = cmd_write_q;
            rd_d[REEN_BIT]  = cmd_reen_q;
            rd_d[BUSY_BIT]  = region_busy_q;
         end
         ZPTR_OFS:  rd_d[15:0] = zptr_q;
         STORE_OFS: rd_d = 32'h0000_0000;
         DATA_OFS: begin
            err_d     = blocked;
            rd_d[7:0] = zptr_q[0] ? flash_rdata[15:8] : flash_rdata[7:0];
         end
         INFO_OFS: begin
            rd_d[15:0]     = boot_reset_addr_q;
            rd_d[PROT_BIT] = dz.in_prot;
         end
         default:   err_d = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc && err_d && !(pwrite && paddr == DATA_OFS);  // Loads never refused.
         if (acc && !pwrite) begin
            prdata_q <= err_d ? 32'h0000_0000 : rd_d;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence arm_s;
      (st_q == ST_IDLE) && wr_ctrl && pwdata[SE_BIT];
   endsequence
   sequence quiet4_s;
      (!spm_go)[*4];
   endsequence

   open_busy_a:   assert property (prog_start && !dz.in_prot |=>
                     region_busy_q && !cpu_stall_q)
                  else $error("busy flag not set for region program");
   prot_stall_a:  assert property (prog_start && dz.in_prot |=>
                     cpu_stall_q && st_q == ST_PROG)
                  else $error("core not stalled for protected page");
   stall_hold_a:  assert property (cpu_stall_q && !prog_done |=> cpu_stall_q)
                  else $error("stall dropped before completion");
   window_lapse_a: assert property (arm_s ##1 quiet4_s |=>
                     st_q == ST_IDLE && !store_enable_q)
                  else $error("command did not lapse after four cycles");
   window_open_a: assert property (arm_s ##1 (!spm_go)[*3] |=>
                     st_q == ST_ARMED)
                  else $error("command lapsed too early");
   reenable_a:    assert property (reen_go |=> !region_busy_q && !store_enable_q)
                  else $error("re-enable did not clear busy flag");
   buf_load_a:    assert property (load_go |=>
                     buf_mem[$past(dz.word_sel)] == $past(data_q))
                  else $error("page buffer word not loaded");
   page_sel_a:    assert property (prog_start |=>
                     16'(prog_page_q) == (($past(zptr_q) >> (PWT + 2)) & PMASK))
                  else $error("wrong page taken for program");
   word_sel_a:    assert property (16'(dz.word_sel) == ((zptr_q >> 1) & WMASK))
                  else $error("word field misplaced");
   boot_start_a:  assert property (##1 17'(boot_reset_addr_q)
                     + (17'(BOOT_MIN[VARIANT]) << (~$past(fuse_q))) == FLASH_W)
                  else $error("boot section does not end at top of flash");
   prot_bound_a:  assert property ((17'(zptr_q[15:1]) < FLASH_W) |->
                     dz.in_prot == ({1'b0, zptr_q[15:1]} >= PROT_START[VARIANT]))
                  else $error("region boundary misplaced");
   blocked_rd_a:  assert property (acc && !pwrite && paddr == DATA_OFS && blocked |=>
                     pready_q && pslverr_q)
                  else $error("busy region read not refused");
   byte_sel_a:    assert property (acc && !pwrite && paddr == DATA_OFS && !blocked |=>
                     prdata_q[7:0] == ($past(zptr_q[0]) ? $past(flash_rdata[15:8])
                                                        : $past(flash_rdata[7:0])))
                  else $error("wrong byte returned");
endmodule

// ==== rtl/zmap_decode.sv ====
// Splits the address pointer into page and word fields and places the boot section.
// Assumes the fuse value is already synchronous to the core clock.
`timescale 1ns/1ps
module zmap_decode #(
   parameter zmap_pkg::variant_t VARIANT = zmap_pkg::VAR_16K
) (
   zmap_if.dec z
);
   import zmap_pkg::*;
   localparam int          PWT     = PAGE_TOP[VARIANT];
   localparam int          PCT     = PC_TOP[VARIANT];
   localparam logic [16:0] FLASH_W = 17'(1 << (PCT + 1));
   localparam logic [15:0] WMASK   = 16'((1 << (PWT + 1)) - 1);
   localparam logic [15:0] PMASK   = 16'((1 << (PCT - PWT)) - 1);
   localparam logic [15:0] NPAGE   = PROT_START[VARIANT] >> (PWT + 1);

   logic [15:0] wide_word;
   logic [15:0] wide_page;
   logic [16:0] boot_len;
   logic [16:0] start_w;

   //////////////////////////////////////////////////////////////////////////
   // Pointer bit zero is a byte select, so fields sit one bit higher.
   always_comb begin
      wide_word    = (z.zptr >> 1) & WMASK;
      wide_page    = (z.zptr >> (PWT + 2)) & PMASK;
      boot_len     = 17'(BOOT_MIN[VARIANT]) << (~z.fuse);
      start_w      = FLASH_W - boot_len;
      z.word_sel   = wide_word[6:0];
      z.page_sel   = wide_page[7:0];
      z.in_prot    = wide_page >= NPAGE;
      z.boot_start = start_w[15:0];
   end
endmodule

// ==== rtl/zmap_if.sv ====
// Carrier between the sequencer and the pointer decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface zmap_if;
   logic [15:0] zptr;
   logic [1:0]  fuse;
   logic [7:0]  page_sel;
   logic [6:0]  word_sel;
   logic        in_prot;
   logic [15:0] boot_start;
   modport dec (input zptr, input fuse, output page_sel, output word_sel,
                output in_prot, output boot_start);
   modport ctl (output zptr, output fuse, input page_sel, input word_sel,
                input in_prot, input boot_start);
endinterface

// ==== rtl/zmap_pkg.sv ====
// Constants for flash boot partitioning and pointer decoding.
// Assumes a single core clock and an APB register port.
// Operation
// - 16 KB boot size from two-bit fuse.
// - 16 KB boot start is reset address.
// - 32 KB boot sizes and start addresses.
// - 64 KB boot sizes and start addresses.
// - 16 KB region boundary at word 0x1C00.
// - 32 KB region boundary at word 0x3800.
// - 64 KB region boundary at word 0x7000.
// - Counter width sets page field top bit.
// - 64-word pages, word field Z6 to Z1.
// - 128-word pages, fields Z7:Z1 and Z15:Z8.
// - Erase and write use page field.
// - Page load uses word field as index.
// - Counter bit n maps to pointer n+1.
// - Pointer bit zero picks read byte.
// - Region program sets busy flag, blocks reads.
// - Command lapses unless store within four cycles.
// - Re-enable plus store clears busy flag.
// - Stall core while programming protected region.
package zmap_pkg;
   typedef enum logic [1:0] {VAR_16K, VAR_32K, VAR_64K} variant_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} seq_state_t;

   // Per-variant geometry, indexed by the variant.
   localparam int          PC_TOP     [3] = '{12, 13, 14};
   localparam int          PAGE_TOP   [3] = '{5, 5, 6};
   localparam int          BOOT_MIN   [3] = '{128, 256, 512};
   localparam logic [15:0] PROT_START [3] = '{16'h1C00, 16'h3800, 16'h7000};

   // Register byte offsets.
   localparam logic [7:0]  CTRL_OFS   = 8'h00;
   localparam logic [7:0]  ZPTR_OFS   = 8'h04;
   localparam logic [7:0]  STORE_OFS  = 8'h08;
   localparam logic [7:0]  DATA_OFS   = 8'h0C;
   localparam logic [7:0]  INFO_OFS   = 8'h10;

   // Control register fields; PROT_BIT is a field of the info register.
   localparam int          SE_BIT     = 0;
   localparam int          ERASE_BIT  = 1;
   localparam int          WRITE_BIT  = 2;
   localparam int          REEN_BIT   = 4;
   localparam int          BUSY_BIT   = 6;
   localparam int          PROT_BIT   = 16;

   localparam logic [2:0]  WIN_CYC    = 3'h4;
   localparam logic [2:0]  WIN_LAST   = 3'h1;
   localparam logic [1:0]  FUSE_RST   = 2'h3;
endpackage
